/* core/asuc_defs.svh */
// Offsets, fields and bit timing of the serial core
`ifndef ASUC_DEFS_SVH
`define ASUC_DEFS_SVH

`define ASUC_OFS_DATA 3'h0
`define ASUC_OFS_IEN 3'h1
`define ASUC_OFS_IID 3'h2
`define ASUC_OFS_LFC 3'h3
`define ASUC_OFS_MCTL 3'h4
`define ASUC_OFS_LSTAT 3'h5
`define ASUC_OFS_MSTAT 3'h6
`define ASUC_OFS_SCR 3'h7

`define ASUC_LFC_STOP 2
`define ASUC_LFC_PAREN 3
`define ASUC_LFC_EVEN 4
`define ASUC_LFC_STICK 5
`define ASUC_LFC_BREAK 6
`define ASUC_LFC_DIVSEL 7

`define ASUC_IEN_RXAV 0
`define ASUC_IEN_TXE 1
`define ASUC_IEN_LINE 2
`define ASUC_IEN_MODEM 3

`define ASUC_MCTL_DTR 0
`define ASUC_MCTL_RTS 1
`define ASUC_MCTL_OUT1 2
`define ASUC_MCTL_OUT2 3
`define ASUC_MCTL_LOOP 4

`define ASUC_IID_NONE 8'h01
`define ASUC_IID_LINE 8'h06
`define ASUC_IID_RXAV 8'h04
`define ASUC_IID_TXE 8'h02
`define ASUC_IID_MODEM 8'h00

`define ASUC_TICK_LAST 5'h0f
`define ASUC_START_MID 5'h07
`define ASUC_STOP1_LAST 5'h0f
`define ASUC_STOP15_LAST 5'h17
`define ASUC_STOP2_LAST 5'h1f
`define ASUC_LEN_BASE 3'h4

`endif

/* core/asuc_pkg.sv */
// Types and state record of the serial core
package asuc_pkg;
    typedef logic [2:0] asuc_addr_t;
    typedef logic [7:0] asuc_byte_t;

    typedef enum logic [2:0] {
        ASUC_RX_IDLE = 3'b000,
        ASUC_RX_START = 3'b001,
        ASUC_RX_DATA = 3'b010,
        ASUC_RX_PAR = 3'b011,
        ASUC_RX_STOP = 3'b100
    } asuc_rx_e;

    typedef enum logic [2:0] {
        ASUC_TX_IDLE = 3'b000,
        ASUC_TX_START = 3'b001,
        ASUC_TX_DATA = 3'b010,
        ASUC_TX_PAR = 3'b011,
        ASUC_TX_STOP = 3'b100
    } asuc_tx_e;

    typedef struct packed {
        logic waitreq;
        logic [7:0] rdata;
        logic [3:0] interrupt_enables;
        logic [7:0] line_format_control;
        logic [4:0] modem_control;
        logic [7:0] scratch_byte;
        logic [7:0] divisor_low_byte;
        logic [7:0] divisor_high_byte;
        logic [7:0] receive_buffer;
        logic rx_ready_flag;
        logic overrun_flag;
        logic parity_err_flag;
        logic framing_err_flag;
        logic break_flag;
        logic tx_hold_empty;
        logic txe_irq_flag;
        logic [7:0] transmit_holding;
        logic [15:0] baud_cnt;
        logic tick;
        logic rx_s1;
        logic rx_s2;
        logic rx_prev;
        logic [3:0] mdm_s1;
        logic [3:0] mdm_s2;
        logic [3:0] mdm_stat;
        logic [3:0] mdm_delta;
        asuc_rx_e rx_st;
        logic [4:0] rx_tick;
        logic [2:0] rx_bit;
        logic [7:0] rx_shift;
        logic rx_par;
        asuc_tx_e tx_st;
        logic [4:0] tx_tick;
        logic [2:0] tx_bit;
        logic [7:0] transmit_shifter;
        logic tx_ser;
        logic tx_line;
        logic irq;
        logic [3:0] mdm_out_n;
    } asuc_state_s;
endpackage

/* core/asuc_top.sv */
// Serial transceiver core with Avalon-MM register slave
// Notes on behaviour
// R1 - Receiver takes 5 to 8 bits, right-justified, upper bits zero.
// R2 - Bit zero is the first data bit on the line in both directions.
// R3 - Falling edge on idle-high line starts 16x count to start centre.
// R4 - Start bit accepted only if still low at mid-bit sample.
// R5 - Completed character loads receive buffer, sets data ready.
// R6 - Unread buffer overwritten by next character sets overrun.
// R7 - Transmitter and receiver share character length; stop bit length applies to the transmitter only.
// R8 - Transmitter ignores unused upper holding bits for short characters.
// R9 - Holding empty sets when holding moves to shifter during start bit.
// R10 - Holding write clears holding empty; idle shows both empty flags high.
// R11 - Write during a busy shifter waits; holding empty stays low.
// R12 - Transmitter empty only when holding and shifter are empty.
// R13 - Host writes holding only while holding empty is high.
// R14 - Priority: line status, data available, holding empty, modem status.
// R15 - Identity bit zero low while an enabled interrupt is pending.
// R16 - Identity bits two and one encode the highest pending source.
// R17 - Identity bits three to seven read zero.
// R18 - Each interrupt clears by its own read or write.
// R19 - Identity reports only the highest pending source until serviced.
// R20 - Enable bits gate each source; upper bits read zero.
// R21 - Disabled interrupts inhibit identity and output; status flags still update.
// R22 - Scratch byte stores host data and affects nothing else.
// R23 - Either divisor byte write reloads the 16-bit baud counter.
// R24 - Receive buffer read clears data ready.
// R25 - Stop bit sampled low sets framing error.
// R26 - Modem deltas set on input change (bit two only when its status falls), cleared by status read.
// R27 - Rejected start resumes search; valid start samples every 16 ticks.
// R28 - Interrupt output high whenever any enabled source is pending.
`timescale 1ns/10ps
`include "asuc_defs.svh"

module asuc_top (
    input wire logic REF_CLK,
    input wire logic SRST,
    input wire asuc_pkg::asuc_addr_t AVS_ADDRESS,
    input wire logic AVS_READ,
    input wire logic AVS_WRITE,
    input wire logic [31:0] AVS_WRITEDATA,
    input wire logic [3:0] AVS_BYTEENABLE,
    output logic [31:0] AVS_READDATA,
    output logic AVS_WAITREQUEST,
    input wire logic RX_LINE,
    output logic TX_LINE,
    input wire logic CTS_N,
    input wire logic DSR_N,
    input wire logic RI_N,
    input wire logic DCD_N,
    output logic DTR_N,
    output logic RTS_N,
    output logic OUT1_N,
    output logic OUT2_N,
    output logic IRQ
);
    import asuc_pkg::*;

    asuc_state_s s_r;
    asuc_state_s s_nxt;

    // Keeps the programmed data bits
    function automatic logic [7:0] len_mask(input logic [7:0] data, input logic [1:0] wls);
        logic [7:0] m;
        m = 8'hff >> (3'h3 - {1'b0, wls});
        return data & m;
    endfunction

    // Parity bit of a masked character
    function automatic logic par_bit(input logic [7:0] data, input logic even, input logic stick);
        logic p;
        p = even ? (^data) : ~(^data);
        if (stick)
        begin
            p = ~even;
        end
        return p;
    endfunction

    // Pend bits: {modem, holding empty, data, line}
    function automatic logic [7:0] iid_of(input logic [3:0] pend);
        logic [7:0] v;
        v = `ASUC_IID_NONE;
        if (pend[0])
        begin
            v = `ASUC_IID_LINE;
        end
        else if (pend[1])
        begin
            v = `ASUC_IID_RXAV;
        end
        else if (pend[2])
        begin
            v = `ASUC_IID_TXE;
        end
        else if (pend[3])
        begin
            v = `ASUC_IID_MODEM;
        end
        return v;
    endfunction

    logic [3:0] pend;
    logic [7:0] iid;
    logic [7:0] lstat;
    logic tx_all_empty;
    logic [2:0] len_m1;
    logic divsel;
    logic loop_on;
    logic req;
    logic take;

    always_comb
    begin
        loop_on = s_r.modem_control[`ASUC_MCTL_LOOP];
        divsel = s_r.line_format_control[`ASUC_LFC_DIVSEL];
        len_m1 = {1'b0, s_r.line_format_control[1:0]} + `ASUC_LEN_BASE; // R7
        tx_all_empty = s_r.tx_hold_empty && (s_r.tx_st == ASUC_TX_IDLE); // R12
        pend[0] = s_r.interrupt_enables[`ASUC_IEN_LINE]
            && (s_r.overrun_flag || s_r.parity_err_flag || s_r.framing_err_flag || s_r.break_flag); // R20
        pend[1] = s_r.interrupt_enables[`ASUC_IEN_RXAV] && s_r.rx_ready_flag; // R20
        pend[2] = s_r.interrupt_enables[`ASUC_IEN_TXE] && s_r.txe_irq_flag; // R20
        pend[3] = s_r.interrupt_enables[`ASUC_IEN_MODEM] && (|s_r.mdm_delta); // R20 R21
        iid = iid_of(pend); // R14 R15 R16 R17 R19
        lstat = {1'b0, tx_all_empty, s_r.tx_hold_empty, s_r.break_flag, s_r.framing_err_flag,
                 s_r.parity_err_flag, s_r.overrun_flag, s_r.rx_ready_flag};
        req = AVS_READ || AVS_WRITE;
        take = req && !s_r.waitreq;
    end

    always_comb
    begin
        logic rx_in;
        logic [3:0] stat_now;
        logic [7:0] wd;
        logic [4:0] stop_last;
        rx_in = 1'b1;
        stat_now = 4'h0;
        wd = AVS_WRITEDATA[7:0];
        stop_last = `ASUC_STOP1_LAST;
        s_nxt = s_r;

        // One wait cycle stages the read data
        s_nxt.waitreq = !(req && s_r.waitreq);
        if (req && s_r.waitreq && AVS_READ)
        begin
            unique case (AVS_ADDRESS)
                `ASUC_OFS_DATA: s_nxt.rdata = divsel ? s_r.divisor_low_byte : s_r.receive_buffer;
                `ASUC_OFS_IEN: s_nxt.rdata = divsel ? s_r.divisor_high_byte : {4'h0, s_r.interrupt_enables}; // R20
                `ASUC_OFS_IID: s_nxt.rdata = iid; // R17
                `ASUC_OFS_LFC: s_nxt.rdata = s_r.line_format_control;
                `ASUC_OFS_MCTL: s_nxt.rdata = {3'h0, s_r.modem_control};
                `ASUC_OFS_LSTAT: s_nxt.rdata = lstat;
                `ASUC_OFS_MSTAT: s_nxt.rdata = {s_r.mdm_stat, s_r.mdm_delta};
                `ASUC_OFS_SCR: s_nxt.rdata = s_r.scratch_byte; // R22
            endcase
        end

        // Effects land where waitrequest is low; clears before sets
        if (take && AVS_WRITE && AVS_BYTEENABLE[0])
        begin
            unique case (AVS_ADDRESS)
                `ASUC_OFS_DATA:
                begin
                    if (divsel)
                    begin
                        s_nxt.divisor_low_byte = wd;
                        s_nxt.baud_cnt = {s_r.divisor_high_byte, wd}; // R23
                    end
                    else
                    begin
                        s_nxt.transmit_holding = wd;
                        s_nxt.tx_hold_empty = 1'b0; // R10
                        s_nxt.txe_irq_flag = 1'b0; // R18
                    end
                end
                `ASUC_OFS_IEN:
                begin
                    if (divsel)
                    begin
                        s_nxt.divisor_high_byte = wd;
                        s_nxt.baud_cnt = {wd, s_r.divisor_low_byte}; // R23
                    end
                    else
                    begin
                        s_nxt.interrupt_enables = wd[3:0];
                    end
                end
                `ASUC_OFS_LFC: s_nxt.line_format_control = wd;
                `ASUC_OFS_MCTL: s_nxt.modem_control = wd[4:0];
                `ASUC_OFS_SCR: s_nxt.scratch_byte = wd; // R22
                default:
                begin
                end
            endcase
        end
        if (take && AVS_READ)
        begin
            if (AVS_ADDRESS == `ASUC_OFS_DATA && !divsel)
            begin
                s_nxt.rx_ready_flag = 1'b0; // R24 R18
            end
            // Judged on the identity value the host got
            if (AVS_ADDRESS == `ASUC_OFS_IID && s_r.rdata == `ASUC_IID_TXE)
            begin
                s_nxt.txe_irq_flag = 1'b0; // R18
            end
            if (AVS_ADDRESS == `ASUC_OFS_LSTAT)
            begin
                s_nxt.overrun_flag = 1'b0; // R18
                s_nxt.parity_err_flag = 1'b0;
                s_nxt.framing_err_flag = 1'b0;
                s_nxt.break_flag = 1'b0;
            end
            if (AVS_ADDRESS == `ASUC_OFS_MSTAT)
            begin
                s_nxt.mdm_delta = 4'h0; // R26 R18
            end
        end

        // A zero divisor stops the 16x ticks
        s_nxt.tick = 1'b0;
        if (!(take && AVS_WRITE && divsel && (AVS_ADDRESS == `ASUC_OFS_DATA || AVS_ADDRESS == `ASUC_OFS_IEN)))
        begin
            if ({s_r.divisor_high_byte, s_r.divisor_low_byte} != 16'h0000)
            begin
                if (s_r.baud_cnt <= 16'h0001)
                begin
                    s_nxt.baud_cnt = {s_r.divisor_high_byte, s_r.divisor_low_byte};
                    s_nxt.tick = 1'b1;
                end
                else
                begin
                    s_nxt.baud_cnt = s_r.baud_cnt - 16'h0001;
                end
            end
        end

        // Status is the inverse of the pins, or control bits in loopback
        s_nxt.mdm_s1 = {DCD_N, RI_N, DSR_N, CTS_N};
        s_nxt.mdm_s2 = s_r.mdm_s1;
        stat_now = loop_on ? {s_r.modem_control[`ASUC_MCTL_OUT2], s_r.modem_control[`ASUC_MCTL_OUT1],
                              s_r.modem_control[`ASUC_MCTL_DTR], s_r.modem_control[`ASUC_MCTL_RTS]}
                           : ~s_r.mdm_s2;
        s_nxt.mdm_stat = stat_now;
        s_nxt.mdm_delta[0] = s_nxt.mdm_delta[0] || (stat_now[0] != s_r.mdm_stat[0]); // R26
        s_nxt.mdm_delta[1] = s_nxt.mdm_delta[1] || (stat_now[1] != s_r.mdm_stat[1]); // R26
        s_nxt.mdm_delta[2] = s_nxt.mdm_delta[2] || (s_r.mdm_stat[2] && !stat_now[2]); // R26
        s_nxt.mdm_delta[3] = s_nxt.mdm_delta[3] || (stat_now[3] != s_r.mdm_stat[3]); // R26

        // Receiver
        s_nxt.rx_s1 = RX_LINE;
        s_nxt.rx_s2 = s_r.rx_s1;
        rx_in = loop_on ? s_r.tx_ser : s_r.rx_s2;
        if (s_r.tick)
        begin
            s_nxt.rx_prev = rx_in;
            unique case (s_r.rx_st)
                ASUC_RX_IDLE:
                begin
                    if (s_r.rx_prev && !rx_in) // R3
                    begin
                        s_nxt.rx_tick = 5'h00;
                        s_nxt.rx_st = ASUC_RX_START;
                    end
                end
                ASUC_RX_START:
                begin
                    if (s_r.rx_tick == `ASUC_START_MID) // R3
                    begin
                        s_nxt.rx_tick = 5'h00;
                        s_nxt.rx_bit = 3'h0;
                        s_nxt.rx_shift = 8'h00;
                        // A spike that is gone by mid-bit is dropped
                        s_nxt.rx_st = rx_in ? ASUC_RX_IDLE : ASUC_RX_DATA; // R4 R27
                    end
                    else
                    begin
                        s_nxt.rx_tick = s_r.rx_tick + 5'h01;
                    end
                end
                ASUC_RX_DATA:
                begin
                    if (s_r.rx_tick == `ASUC_TICK_LAST) // R27
                    begin
                        s_nxt.rx_tick = 5'h00;
                        s_nxt.rx_shift[s_r.rx_bit] = rx_in; // R2 R1
                        s_nxt.rx_bit = s_r.rx_bit + 3'h1;
                        if (s_r.rx_bit == len_m1)
                        begin
                            s_nxt.rx_st = s_r.line_format_control[`ASUC_LFC_PAREN] ? ASUC_RX_PAR : ASUC_RX_STOP;
                        end
                    end
                    else
                    begin
                        s_nxt.rx_tick = s_r.rx_tick + 5'h01;
                    end
                end
                ASUC_RX_PAR:
                begin
                    if (s_r.rx_tick == `ASUC_TICK_LAST)
                    begin
                        s_nxt.rx_tick = 5'h00;
                        s_nxt.rx_par = rx_in;
                        s_nxt.rx_st = ASUC_RX_STOP;
                    end
                    else
                    begin
                        s_nxt.rx_tick = s_r.rx_tick + 5'h01;
                    end
                end
                ASUC_RX_STOP:
                begin
                    if (s_r.rx_tick == `ASUC_TICK_LAST)
                    begin
                        s_nxt.rx_tick = 5'h00;
                        s_nxt.rx_st = ASUC_RX_IDLE;
                        s_nxt.receive_buffer = s_r.rx_shift; // R5 R1
                        s_nxt.overrun_flag = s_r.rx_ready_flag || s_nxt.overrun_flag; // R6
                        s_nxt.rx_ready_flag = 1'b1; // R5
                        s_nxt.framing_err_flag = s_nxt.framing_err_flag || !rx_in; // R25
                        if (s_r.line_format_control[`ASUC_LFC_PAREN]
                            && s_r.rx_par != par_bit(s_r.rx_shift, s_r.line_format_control[`ASUC_LFC_EVEN],
                                                     s_r.line_format_control[`ASUC_LFC_STICK]))
                        begin
                            s_nxt.parity_err_flag = 1'b1;
                        end
                        // Break: data, parity and stop all low
                        if (s_r.rx_shift == 8'h00 && !rx_in
                            && !(s_r.line_format_control[`ASUC_LFC_PAREN] && s_r.rx_par))
                        begin
                            s_nxt.break_flag = 1'b1;
                        end
                    end
                    else
                    begin
                        s_nxt.rx_tick = s_r.rx_tick + 5'h01;
                    end
                end
                default:
                begin
                    s_nxt.rx_st = ASUC_RX_IDLE;
                end
            endcase
        end

        // Stop length 1, 1.5 (5-bit) or 2 bits
        if (s_r.line_format_control[`ASUC_LFC_STOP])
        begin
            stop_last = (s_r.line_format_control[1:0] == 2'b00) ? `ASUC_STOP15_LAST : `ASUC_STOP2_LAST; // R7
        end
        if (s_r.tick)
        begin
            unique case (s_r.tx_st)
                ASUC_TX_IDLE:
                begin
                    // Holding waits for an idle shifter
                    if (!s_r.tx_hold_empty) // R11
                    begin
                        s_nxt.transmit_shifter = len_mask(s_r.transmit_holding, s_r.line_format_control[1:0]); // R8
                        s_nxt.tx_hold_empty = 1'b1; // R9
                        s_nxt.txe_irq_flag = 1'b1; // R9
                        s_nxt.tx_ser = 1'b0;
                        s_nxt.tx_tick = 5'h00;
                        s_nxt.tx_st = ASUC_TX_START;
                    end
                end
                ASUC_TX_START:
                begin
                    if (s_r.tx_tick == `ASUC_TICK_LAST)
                    begin
                        s_nxt.tx_tick = 5'h00;
                        s_nxt.tx_bit = 3'h0;
                        s_nxt.tx_ser = s_r.transmit_shifter[0]; // R2
                        s_nxt.tx_st = ASUC_TX_DATA;
                    end
                    else
                    begin
                        s_nxt.tx_tick = s_r.tx_tick + 5'h01;
                    end
                end
                ASUC_TX_DATA:
                begin
                    if (s_r.tx_tick == `ASUC_TICK_LAST)
                    begin
                        s_nxt.tx_tick = 5'h00;
                        s_nxt.tx_bit = s_r.tx_bit + 3'h1;
                        if (s_r.tx_bit == len_m1) // R7
                        begin
                            if (s_r.line_format_control[`ASUC_LFC_PAREN])
                            begin
                                s_nxt.tx_ser = par_bit(s_r.transmit_shifter, s_r.line_format_control[`ASUC_LFC_EVEN],
                                                       s_r.line_format_control[`ASUC_LFC_STICK]);
                                s_nxt.tx_st = ASUC_TX_PAR;
                            end
                            else
                            begin
                                s_nxt.tx_ser = 1'b1;
                                s_nxt.tx_st = ASUC_TX_STOP;
                            end
                        end
                        else
                        begin
                            s_nxt.tx_ser = s_r.transmit_shifter[s_r.tx_bit + 3'h1]; // R2
                        end
                    end
                    else
                    begin
                        s_nxt.tx_tick = s_r.tx_tick + 5'h01;
                    end
                end
                ASUC_TX_PAR:
                begin
                    if (s_r.tx_tick == `ASUC_TICK_LAST)
                    begin
                        s_nxt.tx_tick = 5'h00;
                        s_nxt.tx_ser = 1'b1;
                        s_nxt.tx_st = ASUC_TX_STOP;
                    end
                    else
                    begin
                        s_nxt.tx_tick = s_r.tx_tick + 5'h01;
                    end
                end
                ASUC_TX_STOP:
                begin
                    if (s_r.tx_tick == stop_last)
                    begin
                        s_nxt.tx_tick = 5'h00;
                        s_nxt.tx_st = ASUC_TX_IDLE; // R12
                    end
                    else
                    begin
                        s_nxt.tx_tick = s_r.tx_tick + 5'h01;
                    end
                end
                default:
                begin
                    s_nxt.tx_st = ASUC_TX_IDLE;
                end
            endcase
        end

        // Loopback parks the line and modem outputs high
        s_nxt.tx_line = loop_on || (s_r.tx_ser && !s_r.line_format_control[`ASUC_LFC_BREAK]);
        s_nxt.mdm_out_n = loop_on ? 4'hf : ~s_r.modem_control[3:0];
        s_nxt.irq = |pend; // R28 R21

        if (SRST)
        begin
            s_nxt = '0;
            s_nxt.waitreq = 1'b1;
            s_nxt.tx_hold_empty = 1'b1; // R10
            s_nxt.txe_irq_flag = 1'b1;
            s_nxt.rx_s1 = 1'b1;
            s_nxt.rx_s2 = 1'b1;
            s_nxt.rx_prev = 1'b1;
            s_nxt.mdm_s1 = 4'hf;
            s_nxt.mdm_s2 = 4'hf;
            s_nxt.rx_st = ASUC_RX_IDLE;
            s_nxt.tx_st = ASUC_TX_IDLE;
            s_nxt.tx_ser = 1'b1;
            s_nxt.tx_line = 1'b1;
            s_nxt.mdm_out_n = 4'hf;
        end
    end

    always_ff @(posedge REF_CLK)
    begin
        s_r <= s_nxt;
    end

    assign AVS_READDATA = {24'h000000, s_r.rdata};
    assign AVS_WAITREQUEST = s_r.waitreq;
    assign TX_LINE = s_r.tx_line;
    assign IRQ = s_r.irq;
    assign DTR_N = s_r.mdm_out_n[`ASUC_MCTL_DTR];
    assign RTS_N = s_r.mdm_out_n[`ASUC_MCTL_RTS];
    assign OUT1_N = s_r.mdm_out_n[`ASUC_MCTL_OUT1];
    assign OUT2_N = s_r.mdm_out_n[`ASUC_MCTL_OUT2];
endmodule // asuc_top

/* test/asuc_properties.sv */
// Port-level checks of the serial core
`timescale 1ns/10ps
module asuc_properties (
    input wire logic REF_CLK,
    input wire logic SRST,
    input wire asuc_pkg::asuc_addr_t AVS_ADDRESS,
    input wire logic AVS_READ,
    input wire logic AVS_WRITE,
    input wire logic [31:0] AVS_READDATA,
    input wire logic AVS_WAITREQUEST,
    input wire logic TX_LINE,
    input wire logic IRQ
);
    import asuc_pkg::*;
    logic rd_ok;
    assign rd_ok = AVS_READ && !AVS_WAITREQUEST;
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (SRST);
    a_wait_answer: assert property ((AVS_READ || AVS_WRITE) && AVS_WAITREQUEST |=> !AVS_WAITREQUEST)
        else $error("no answer");
    a_wait_single: assert property (!AVS_WAITREQUEST |=> AVS_WAITREQUEST)
        else $error("answer too long");
    a_iid_upper: assert property (rd_ok && AVS_ADDRESS == 3'h2 |-> AVS_READDATA[7:3] == 5'h00)
        else $error("identity upper set");
    a_iid_none: assert property (rd_ok && AVS_ADDRESS == 3'h2 && AVS_READDATA[0] |-> !AVS_READDATA[2:1])
        else $error("bad idle identity");
    a_empty_order: assert property (rd_ok && AVS_ADDRESS == 3'h5 && AVS_READDATA[6] |-> AVS_READDATA[5])
        else $error("empty flags crossed");
    a_start_width: assert property ($fell(TX_LINE) |=> !TX_LINE [*8])
        else $error("start bit short");
    a_reset_idle: assert property ($fell(SRST) |-> !IRQ && TX_LINE)
        else $error("not idle after reset");
    a_rdata_zero: assert property (rd_ok |-> AVS_READDATA[31:8] == 24'h0)
        else $error("read upper set");
endmodule // asuc_properties

bind asuc_top asuc_properties i_props (.REF_CLK(REF_CLK), .SRST(SRST), .AVS_ADDRESS(AVS_ADDRESS),
    .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE), .AVS_READDATA(AVS_READDATA),
    .AVS_WAITREQUEST(AVS_WAITREQUEST), .TX_LINE(TX_LINE), .IRQ(IRQ));

/* test/asuc_far_end.sv */
// Far-end terminal; divisor 1 makes a bit 16 clocks
`timescale 1ns/10ps
module asuc_far_end (
    input wire logic clk,
    input wire logic tx_line,
    output logic rx_line
);
    initial rx_line = 1'b1;
    task bit_out(input logic b);
        rx_line <= b;
        repeat (16) @(posedge clk);
    endtask
    task send(input logic [7:0] d, input int n, input logic stop);
        bit_out(1'b0);
        for (int i = 0; i < n; i++)
            bit_out(d[i]);
        bit_out(stop);
        bit_out(1'b1);
    endtask
    // Low spike under half a bit
    task spike();
        rx_line <= 1'b0;
        repeat (4) @(posedge clk);
        bit_out(1'b1);
        bit_out(1'b1);
    endtask
    task grab(input int n, output logic [7:0] d);
        d = 8'h00;
        wait (tx_line === 1'b1);
        wait (tx_line === 1'b0);
        repeat (8) @(posedge clk);
        for (int i = 0; i < n; i++)
        begin
            repeat (16) @(posedge clk);
            d[i] = tx_line;
        end
    endtask
endmodule // asuc_far_end

/* test/tb_async_serial_uart_core.sv */
// Self-checking bench for the serial core
`timescale 1ns/10ps
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin fail_count++; \
    $display("FAIL t=%0t got %h exp %h", $time, g, e); end end
module tb_async_serial_uart_core;
    import asuc_pkg::*;
    logic REF_CLK = 1'b0, SRST = 1'b1, AVS_READ = 1'b0, AVS_WRITE = 1'b0;
    asuc_addr_t AVS_ADDRESS = 3'h0;
    logic [31:0] AVS_WRITEDATA = 32'h0, AVS_READDATA;
    logic AVS_WAITREQUEST, RX_LINE, TX_LINE, IRQ;
    int checked = 0, fail_count = 0, cyc = 0;
    asuc_byte_t q;
    asuc_byte_t d1, d2;
    always #5 REF_CLK = ~REF_CLK;
    asuc_top i_dut (.REF_CLK(REF_CLK), .SRST(SRST), .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ),
        .AVS_WRITE(AVS_WRITE), .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_BYTEENABLE(4'h1),
        .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST), .RX_LINE(RX_LINE),
        .TX_LINE(TX_LINE), .CTS_N(1'b1), .DSR_N(1'b1), .RI_N(1'b1), .DCD_N(1'b1), .DTR_N(),
        .RTS_N(), .OUT1_N(), .OUT2_N(), .IRQ(IRQ));
    asuc_far_end i_far (.clk(REF_CLK), .tx_line(TX_LINE), .rx_line(RX_LINE));
    task bus(input logic w, input asuc_addr_t a, input asuc_byte_t d);
        AVS_ADDRESS <= a;
        AVS_WRITEDATA <= {24'h0, d};
        AVS_WRITE <= w;
        AVS_READ <= !w;
        @(posedge REF_CLK);
        while (AVS_WAITREQUEST !== 1'b0)
            @(posedge REF_CLK);
        q = AVS_READDATA[7:0];
        AVS_READ <= 1'b0;
        AVS_WRITE <= 1'b0;
        @(posedge REF_CLK);
    endtask
    task rc(input asuc_addr_t a, input asuc_byte_t e);
        bus(1'b0, a, 8'h00);
        `CHK(q, e)
    endtask
    task test_done();
        $display("checks %0d mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task t_rx();
        i_far.send(8'h3c, 8, 1'b1);
        rc(3'h5, 8'h61);
        rc(3'h0, 8'h3c);
        rc(3'h5, 8'h60);
        i_far.send(8'h11, 8, 1'b1);
        i_far.send(8'h22, 8, 1'b1);
        rc(3'h5, 8'h63);
        rc(3'h0, 8'h22);
        i_far.spike();
        rc(3'h5, 8'h60);
        bus(1'b1, 3'h3, 8'h00);
        i_far.send(8'hff, 5, 1'b1);
        rc(3'h0, 8'h1f);
        $display("rx done");
    endtask
    task t_tx();
        fork
            i_far.grab(6, d1);
            bus(1'b1, 3'h0, 8'hd5);
        join
        `CHK(d1, 8'h35)
        rc(3'h5, 8'h20);
        repeat (40) @(posedge REF_CLK);
        bus(1'b1, 3'h3, 8'h03);
        fork
            i_far.grab(8, d1);
            begin
                bus(1'b1, 3'h0, 8'h5a);
                rc(3'h5, 8'h20);
                bus(1'b1, 3'h0, 8'hc3);
                rc(3'h5, 8'h00);
            end
        join
        i_far.grab(8, d2);
        `CHK(d1, 8'h5a)
        `CHK(d2, 8'hc3)
        repeat (40) @(posedge REF_CLK);
        rc(3'h5, 8'h60);
        $display("tx done");
    endtask
    task t_irq();
        bus(1'b1, 3'h1, 8'h02);
        @(posedge REF_CLK);
        `CHK(IRQ, 1'b1)
        rc(3'h2, 8'h02);
        rc(3'h2, 8'h01);
        @(posedge REF_CLK);
        `CHK(IRQ, 1'b0)
        bus(1'b1, 3'h1, 8'hf7);
        rc(3'h1, 8'h07);
        i_far.send(8'h55, 8, 1'b1);
        rc(3'h2, 8'h04);
        i_far.send(8'h56, 8, 1'b0);
        rc(3'h2, 8'h06);
        rc(3'h5, 8'h6b);
        rc(3'h2, 8'h04);
        rc(3'h0, 8'h56);
        rc(3'h2, 8'h01);
        $display("irq done");
    endtask
    always @(posedge REF_CLK)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            fail_count++;
            test_done();
        end
    end
    initial
    begin
        repeat (10) @(posedge REF_CLK);
        SRST <= 1'b0;
        @(posedge REF_CLK);
        bus(1'b1, 3'h3, 8'h80);
        bus(1'b1, 3'h0, 8'h01);
        bus(1'b1, 3'h1, 8'h00);
        bus(1'b1, 3'h3, 8'h03);
        bus(1'b1, 3'h7, 8'ha5);
        rc(3'h7, 8'ha5);
        rc(3'h5, 8'h60);
        t_rx();
        t_tx();
        t_irq();
        test_done();
    end
endmodule // tb_async_serial_uart_core
